// ### hw/npi_host.sv
// host controller driving an asynchronous parallel flash over its pins
// Behaviour
// - address select low except address loading
// - command select low except command loading
// - select may drop during program/erase
// - busy is open drain, pulled up
// - full address is five byte cycles
// - phase select latched only when selected
module npi_host #(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic mclk, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic ce, // clock enable, freezes state when low
	input wire logic [1:0] req_kind, // cmd, addr, write, read
	input wire logic req_valid, // request strobe
	output logic req_ready, // controller idle
	input wire logic req_die, // 0 first select, 1 second select
	input wire logic [7:0] req_cmd, // command byte
	input wire logic [39:0] req_addr, // five address bytes, low first
	input wire logic [7:0] req_count, // bytes to move, 0 means 256
	input wire logic req_keep_select, // hold select after transfer
	input wire logic [7:0] wr_data, // write data in
	input wire logic wr_valid, // write data valid
	output logic wr_ready, // write fifo can take data
	output logic [7:0] rd_data, // read byte
	output logic rd_valid, // read byte pulse
	input wire logic guard_in, // host wants programming allowed
	output logic chip_select_n, // first select
	output logic second_chip_select_n, // second select
	output logic cmd_phase_select, // command phase
	output logic addr_phase_select, // address phase
	output logic input_strobe_n, // host to device strobe
	output logic output_strobe_n, // device to host strobe
	output logic program_guard_n, // write protect, low blocks program
	output logic [7:0] bus_out, // shared bus drive value
	output logic bus_oe, // high while host drives the bus
	input wire logic [7:0] bus_in, // shared bus sampled
	input wire logic busy_flag_n, // open drain busy, pulled up off chip
	input wire logic second_busy_flag_n, // busy for second half
	output logic ready_first, // filtered ready of first half
	output logic ready_second // filtered ready of second half
);
	npi_pkg::npi_state_e state;
	logic [1:0] kind;
	logic [39:0] abuf;
	logic [7:0] cmd;
	logic [7:0] left;
	logic [3:0] tcnt;
	logic [1:0] s1, s2, s3;
	logic [7:0] bus_s1, bus_s2, bus_s3, bus_seen;
	logic [7:0] fifo_data;
	logic fifo_valid;
	logic fifo_pop;
	logic fifo_in_ready;

	// true when the current phase drives the bus
	function automatic logic drives(input logic [1:0] k);
		drives = (k != npi_pkg::KIND_READ);
	endfunction : drives

	// write data waits here; the strobe engine stalls when it runs dry
	npi_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.rstn(rstn),
		.ce(ce),
		.in_data(wr_data),
		.in_valid(wr_valid),
		.in_ready(fifo_in_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);
	assign fifo_pop = ce && state == npi_pkg::NPI_NEXT && kind == npi_pkg::KIND_WRITE;

	// three-stage sync of busy pins and the bus; agree of 2nd and 3rd counts
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1 <= 2'h3;
			s2 <= 2'h3;
			s3 <= 2'h3;
			bus_s1 <= 8'h00;
			bus_s2 <= 8'h00;
			bus_s3 <= 8'h00;
			bus_seen <= 8'h00;
			ready_first <= 1'b0;
			ready_second <= 1'b0;
		end
		else if (ce)
		begin
			s1 <= {second_busy_flag_n, busy_flag_n};
			s2 <= s1;
			s3 <= s2;
			bus_s1 <= bus_in; // read strobe must stay low five cycles to clear this
			bus_s2 <= bus_s1;
			bus_s3 <= bus_s2;
			if (bus_s2 == bus_s3)
				bus_seen <= bus_s3;
			if (s2[0] == s3[0])
				ready_first <= s3[0];
			if (s2[1] == s3[1])
				ready_second <= s3[1];
		end
	end

	// guard pin follows the host wish; low blocks program and erase
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			program_guard_n <= 1'b0;
		else if (ce)
			program_guard_n <= guard_in;
	end

	// strobe engine: setup, strobe low, strobe high, next byte
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= npi_pkg::NPI_IDLE;
			kind <= npi_pkg::KIND_CMD;
			abuf <= '0;
			cmd <= '0;
			left <= '0;
			tcnt <= '0;
			chip_select_n <= 1'b1;
			second_chip_select_n <= 1'b1;
			cmd_phase_select <= 1'b0;
			addr_phase_select <= 1'b0;
			input_strobe_n <= 1'b1;
			output_strobe_n <= 1'b1;
			bus_out <= '0;
			bus_oe <= 1'b0;
			rd_data <= '0;
			rd_valid <= 1'b0;
			req_ready <= 1'b1;
			wr_ready <= 1'b0;
		end
		else if (ce)
		begin
			rd_valid <= 1'b0;
			wr_ready <= fifo_in_ready;
			case (state)
				npi_pkg::NPI_IDLE:
				begin
					if (req_valid)
					begin
						kind <= req_kind;
						cmd <= req_cmd;
						abuf <= req_addr;
						req_ready <= 1'b0;
						chip_select_n <= req_die;
						second_chip_select_n <= !req_die;
						left <= (req_kind == npi_pkg::KIND_CMD) ? 8'h01 :
							(req_kind == npi_pkg::KIND_ADDR) ? 8'(npi_pkg::ADDR_BYTES) :
							req_count;
						// only one select at a time, never both
						cmd_phase_select <= (req_kind == npi_pkg::KIND_CMD);
						addr_phase_select <= (req_kind == npi_pkg::KIND_ADDR);
						tcnt <= '0;
						state <= npi_pkg::NPI_SETUP;
					end
				end
				npi_pkg::NPI_SETUP:
				begin
					// wait for write data rather than strobe garbage
					if (kind != npi_pkg::KIND_WRITE || fifo_valid)
					begin
						bus_oe <= drives(kind);
						bus_out <= (kind == npi_pkg::KIND_CMD) ? cmd :
							(kind == npi_pkg::KIND_ADDR) ? abuf[7:0] : fifo_data;
						if (kind == npi_pkg::KIND_READ)
							output_strobe_n <= 1'b0;
						else
							input_strobe_n <= 1'b0;
						tcnt <= '0;
						state <= npi_pkg::NPI_LOW;
					end
				end
				npi_pkg::NPI_LOW:
				begin
					tcnt <= tcnt + 4'h1;
					if (tcnt == 4'(npi_pkg::STROBE_LOW_CYC - 1))
					begin
						// rising edge latches the byte in the device
						input_strobe_n <= 1'b1;
						output_strobe_n <= 1'b1;
						if (kind == npi_pkg::KIND_READ)
						begin
							rd_data <= bus_seen;
							rd_valid <= 1'b1;
						end
						tcnt <= '0;
						state <= npi_pkg::NPI_HIGH;
					end
				end
				npi_pkg::NPI_HIGH:
				begin
					tcnt <= tcnt + 4'h1;
					if (tcnt == 4'(npi_pkg::STROBE_HIGH_CYC - 1))
						state <= npi_pkg::NPI_NEXT;
				end
				npi_pkg::NPI_NEXT:
				begin
					abuf <= {8'h00, abuf[39:8]};
					left <= left - 8'h01;
					if (left == 8'h01)
					begin
						cmd_phase_select <= 1'b0;
						addr_phase_select <= 1'b0;
						bus_oe <= 1'b0;
						// dropping select is safe once program/erase is running
						if (!req_keep_select)
						begin
							chip_select_n <= 1'b1;
							second_chip_select_n <= 1'b1;
						end
						req_ready <= 1'b1;
						state <= npi_pkg::NPI_IDLE;
					end
					else
						state <= npi_pkg::NPI_SETUP;
				end
				default:
					state <= npi_pkg::NPI_IDLE;
			endcase
		end
	end

	// phase selects are exclusive
	a_phase_excl: assert property (@(posedge mclk) disable iff (!rstn)
		!(cmd_phase_select && addr_phase_select))
		else $error("both phase selects high");
	// bus released whenever the output strobe is low
	a_read_release: assert property (@(posedge mclk) disable iff (!rstn)
		!output_strobe_n |-> !bus_oe)
		else $error("bus driven during read strobe");
	// strobes only while a select is asserted
	a_strobe_select: assert property (@(posedge mclk) disable iff (!rstn)
		(!input_strobe_n || !output_strobe_n) |-> (!chip_select_n || !second_chip_select_n))
		else $error("strobe without select");
	// address select high only within an address request
	a_addr_low: assert property (@(posedge mclk) disable iff (!rstn)
		addr_phase_select |-> kind == npi_pkg::KIND_ADDR)
		else $error("address select outside address load");
	// command select high only within a command request
	a_cmd_low: assert property (@(posedge mclk) disable iff (!rstn)
		cmd_phase_select |-> kind == npi_pkg::KIND_CMD)
		else $error("command select outside command load");
	// input strobe rises after its low time
	a_strobe_width: assert property (@(posedge mclk) disable iff (!rstn || !ce)
		$fell(input_strobe_n) |-> !input_strobe_n [*5])
		else $error("input strobe low too short");
	// never both selects
	a_one_select: assert property (@(posedge mclk) disable iff (!rstn)
		chip_select_n || second_chip_select_n)
		else $error("both chip selects asserted");
	// host drives bus only when not reading
	a_bus_drive: assert property (@(posedge mclk) disable iff (!rstn)
		bus_oe |-> kind != npi_pkg::KIND_READ)
		else $error("bus driven on read");
	c_cmd: cover property (@(posedge mclk) disable iff (!rstn)
		cmd_phase_select && $rose(input_strobe_n));
	c_addr: cover property (@(posedge mclk) disable iff (!rstn)
		addr_phase_select && $rose(input_strobe_n));
	c_read: cover property (@(posedge mclk) disable iff (!rstn) rd_valid);
endmodule : npi_host

// ### hw/npi_pkg.sv
// package of constants for the host-side parallel flash pin controller
package npi_pkg;
	localparam int CLK_MHZ = 200;
	// strobe low and high phase, in ns, rounded up to whole cycles
	localparam int STROBE_LOW_NS = 25;
	localparam int STROBE_HIGH_NS = 15;
	localparam int STROBE_LOW_CYC = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS * CLK_MHZ + 999) / 1000;
	localparam int ADDR_BYTES = 5;
	localparam int ADDR_W = 40;
	localparam int CNT_W = 8;
	localparam logic [1:0] KIND_CMD = 2'h0;
	localparam logic [1:0] KIND_ADDR = 2'h1;
	localparam logic [1:0] KIND_WRITE = 2'h2;
	localparam logic [1:0] KIND_READ = 2'h3;
	typedef enum logic [2:0] {
		NPI_IDLE = 3'b000,
		NPI_SETUP = 3'b001,
		NPI_LOW = 3'b010,
		NPI_HIGH = 3'b011,
		NPI_NEXT = 3'b100
	} npi_state_e;
endpackage : npi_pkg

// ### hw/npi_fifo.sv
// small valid/ready fifo carrying write data toward the flash pins
module npi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic mclk, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic ce, // clock enable
	input wire logic [WIDTH-1:0] in_data, // fill side data
	input wire logic in_valid, // fill side valid
	output logic in_ready, // fill side ready
	output logic [WIDTH-1:0] out_data, // drain side data
	output logic out_valid, // drain side valid
	input wire logic out_ready // drain side ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wp;
	logic [AW:0] rp;
	logic [AW:0] fill;

	// occupancy decides full and empty honestly
	always_comb
	begin
		fill = wp - rp;
		in_ready = (fill != DEPTH[AW:0]);
		out_valid = (fill != '0);
		out_data = mem[rp[AW-1:0]];
	end

	// pointers advance only on accepted handshakes
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			wp <= '0;
			rp <= '0;
		end
		else if (ce)
		begin
			if (in_valid && in_ready)
				wp <= wp + 1'b1;
			if (out_valid && out_ready)
				rp <= rp + 1'b1;
		end
	end

	// storage needs no reset
	always_ff @(posedge mclk)
	begin
		if (ce && in_valid && in_ready)
			mem[wp[AW-1:0]] <= in_data;
	end
endmodule : npi_fifo

// ### bench/npi_dev_model.sv
// behavioural flash device model facing the host pins
module npi_dev_model #(
	parameter logic [7:0] PROG_CMD = 8'h10, // program confirm code, plain default
	parameter int BUSY_CYC = 40, // shortened array operation time
	parameter logic [7:0] STATUS_CMD = 8'h20, // status read code, plain default
	parameter logic [7:0] RESET_CMD = 8'h30 // reset code, plain default
) (
	input wire logic mclk, // model clock
	input wire logic cs_n, // first select
	input wire logic cs2_n, // second select
	input wire logic cle, // command phase
	input wire logic ale, // address phase
	input wire logic we_n, // input strobe
	input wire logic re_n, // output strobe
	input wire logic wp_n, // guard
	input wire logic [7:0] hdata, // host drive value
	input wire logic hoe, // host drives bus
	output logic [7:0] bus, // resolved bus level
	output logic busy_n // busy line with pull-up
);
	// array shape the model stands for; the pins never carry it directly
	localparam int PLANES = 2;
	localparam int BLOCKS_PER_PLANE = 2048;
	localparam int PAGES_PER_BLOCK = 64;
	localparam int PAGE_MAIN = 2048;
	localparam int PAGE_SPARE = 64;
	logic we_d = 1'b1;
	logic re_d = 1'b1;
	logic [7:0] cmd_q = 8'h00;
	logic [7:0] cmd2_q = 8'h00;
	logic [7:0] last = 8'h00;
	logic [7:0] rptr = 8'h00;
	logic [39:0] addr_q = '0;
	logic [31:0] wdat = '0;
	int bcnt = 0;
	wire dev_oe = ~cs_n & ~re_n & ~hoe;
	// released bus shows the inverse of its last level, so stale data cannot pass
	always_comb bus = hoe ? hdata : (dev_oe ? 8'h3c + rptr : ~last);
	assign busy_n = (bcnt != 0) ? 1'b0 : 1'b1; // only pulls low
	// strobe rises seen one edge late; phase lines and bus still stand then
	always @(posedge mclk)
	begin
		we_d <= we_n;
		re_d <= re_n;
		last <= bus;
		if (bcnt != 0) bcnt <= bcnt - 1;
		if (re_n & ~re_d & ~cs_n) rptr <= rptr + 8'h01;
		if (we_n & ~we_d & ~cs_n)
		begin
			if (cle & (bcnt == 0 | bus == STATUS_CMD | bus == RESET_CMD)) cmd_q <= bus;
			if (ale) addr_q <= {bus, addr_q[39:8]};
			if (~cle & ~ale) wdat <= {bus, wdat[31:8]};
			if (cle & bus == PROG_CMD & wp_n) bcnt <= BUSY_CYC;
		end
		if (we_n & ~we_d & ~cs2_n & cle) cmd2_q <= bus;
	end
endmodule : npi_dev_model

// ### bench/test_npi_host.sv
// self-checking bench for the host flash pin controller
module test_npi_host;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, rstn = 0, req_valid = 0, req_die = 0, wr_valid = 0, guard = 0;
	logic ce_in = 1, keep = 0, rb2_n = 1;
	logic [1:0] kind = 2'h0;
	logic [7:0] cmd = 8'h00, cnt = 8'h01, wdata = 8'h00;
	logic [39:0] addr = '0;
	wire logic req_ready, wr_ready, rd_valid, cs_n, cs2_n, cle, ale, we_n, re_n, wp_n;
	wire logic oe, rb_n, rdy1, rdy2;
	wire logic [7:0] rd_data, hd, bus;
	int fail_count = 0, checked = 0, cyc = 0;
	logic [7:0] rq[$];
	npi_host #(.FIFO_DEPTH(4)) dut (.mclk(mclk), .rstn(rstn), .ce(ce_in), .req_kind(kind),
		.req_valid(req_valid), .req_ready(req_ready), .req_die(req_die), .req_cmd(cmd),
		.req_addr(addr), .req_count(cnt), .req_keep_select(keep), .wr_data(wdata),
		.wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
		.guard_in(guard), .chip_select_n(cs_n), .second_chip_select_n(cs2_n),
		.cmd_phase_select(cle), .addr_phase_select(ale), .input_strobe_n(we_n),
		.output_strobe_n(re_n), .program_guard_n(wp_n), .bus_out(hd), .bus_oe(oe),
		.bus_in(bus), .busy_flag_n(rb_n), .second_busy_flag_n(rb2_n),
		.ready_first(rdy1), .ready_second(rdy2));
	npi_dev_model dev (.mclk(mclk), .cs_n(cs_n), .cs2_n(cs2_n), .cle(cle), .ale(ale),
		.we_n(we_n), .re_n(re_n), .wp_n(wp_n), .hdata(hd), .hoe(oe), .bus(bus), .busy_n(rb_n));
	// clock; a hang past the ceiling counts as a mismatch
	initial forever #2.5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (rd_valid === 1'b1) rq.push_back(rd_data);
		if (cyc == 20000)
		begin
			fail_count++;
			print_verdict();
		end
	end
	task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic go(input logic [1:0] k, input logic d, input logic [7:0] c, input logic [7:0] n);
		@(negedge mclk);
		kind = k;
		req_die = d;
		cmd = c;
		cnt = n;
		req_valid = 1;
		@(negedge mclk);
		req_valid = 0;
	endtask : go
	task automatic fin();
		for (int i = 0; i < 3000 && req_ready !== 1'b1; i++) @(negedge mclk);
		chk("req_ready", 1, req_ready);
	endtask : fin
	task automatic t_cmd_addr();
		go(npi_pkg::KIND_CMD, 0, 8'h5a, 8'h01);
		fin();
		chk("cmd", 8'h5a, dev.cmd_q);
		chk("addr idle", 0, dev.addr_q);
		addr = 40'h12_3456_789a;
		go(npi_pkg::KIND_ADDR, 0, 8'h00, 8'h01);
		fin();
		chk("addr", 40'h12_3456_789a, dev.addr_q);
		chk("cmd kept", 8'h5a, dev.cmd_q);
		chk("page bytes", 40'h840, dev.PAGE_MAIN + dev.PAGE_SPARE);
		chk("plane pages", 40'h4_0000, dev.PLANES * dev.BLOCKS_PER_PLANE * dev.PAGES_PER_BLOCK);
		$display("t_cmd_addr done");
	endtask : t_cmd_addr
	task automatic t_write();
		for (int i = 0; i < 4; i++)
		begin
			@(negedge mclk);
			wdata = 8'h80 + i[7:0];
			wr_valid = 1;
		end
		@(negedge mclk);
		wr_valid = 0;
		@(negedge mclk);
		chk("wr_ready full", 0, wr_ready);
		go(npi_pkg::KIND_WRITE, 0, 8'h00, 8'h05);
		repeat (80) @(negedge mclk);
		chk("stall", 0, req_ready);
		wdata = 8'h84;
		wr_valid = 1;
		@(negedge mclk);
		wr_valid = 0;
		fin();
		chk("wdata", 32'h8483_8281, dev.wdat);
		chk("wr_ready", 1, wr_ready);
		$display("t_write done");
	endtask : t_write
	task automatic t_read();
		logic [7:0] p;
		p = dev.rptr;
		rq.delete();
		go(npi_pkg::KIND_READ, 0, 8'h00, 8'h03);
		fin();
		chk("rd count", 3, rq.size());
		for (int i = 0; i < 3; i++) chk("rd", 8'h3c + p + i[7:0], rq[i]);
		$display("t_read done");
	endtask : t_read
	task automatic t_die();
		keep = 1;
		go(npi_pkg::KIND_CMD, 1, 8'h77, 8'h01);
		@(negedge mclk);
		ce_in = 0;
		repeat (30) @(negedge mclk);
		chk("frozen", 0, req_ready);
		ce_in = 1;
		fin();
		keep = 0;
		chk("cmd2", 8'h77, dev.cmd2_q);
		chk("cmd1 kept", 8'h5a, dev.cmd_q);
		chk("kept select", 0, cs2_n);
		rb2_n = 0;
		for (int i = 0; i < 10 && rdy2 !== 1'b0; i++) @(negedge mclk);
		chk("busy2", 0, rdy2);
		rb2_n = 1;
		for (int i = 0; i < 10 && rdy2 !== 1'b1; i++) @(negedge mclk);
		chk("ready2", 1, rdy2);
		$display("t_die done");
	endtask : t_die
	task automatic t_busy();
		int lows;
		lows = 0;
		chk("guard", 0, wp_n);
		go(npi_pkg::KIND_CMD, 0, 8'h10, 8'h01);
		fin();
		repeat (60) @(negedge mclk) lows += (rdy1 !== 1'b1);
		chk("no busy", 0, lows);
		guard = 1;
		go(npi_pkg::KIND_CMD, 0, 8'h10, 8'h01);
		fin();
		for (int i = 0; i < 30 && rdy1 !== 1'b0; i++) @(negedge mclk);
		chk("busy", 0, rdy1);
		go(npi_pkg::KIND_CMD, 0, dev.STATUS_CMD, 8'h01);
		fin();
		chk("status in busy", dev.STATUS_CMD, dev.cmd_q);
		for (int i = 0; i < 80 && rdy1 !== 1'b1; i++) @(negedge mclk);
		chk("ready", 1, rdy1);
		$display("t_busy done");
	endtask : t_busy
	task automatic print_verdict();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict
	initial
	begin
		repeat (8) @(posedge mclk);
		@(negedge mclk) rstn = 1;
		repeat (8) @(negedge mclk);
		chk("ready idle", 1, rdy1);
		t_cmd_addr();
		t_write();
		t_read();
		t_die();
		t_busy();
		print_verdict();
	end
endmodule : test_npi_host
